/* common/gpio_steer_pkg.sv */
// Constants, types and helpers shared by the port and pin steering block
package gpio_steer_pkg;
   localparam int PORT_W = 6;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int REG_W = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_DIR = 8'h00;
   localparam logic [7:0] OFS_PIN = 8'h04;
   localparam logic [7:0] OFS_LAT = 8'h08;
   localparam logic [7:0] OFS_ANS = 8'h0C;
   localparam logic [7:0] OFS_STEER = 8'h10;

   // Implemented bits, forced bits and reset values
   localparam logic [7:0] DIR_MASK = 8'h37;
   localparam logic [7:0] DIR_FORCE = 8'h08;
   localparam logic [7:0] DIR_RESET = 8'h3F;
   localparam logic [7:0] LAT_MASK = 8'h37;
   localparam logic [7:0] LAT_RESET = 8'h00;
   localparam logic [7:0] ANS_MASK = 8'h17;
   localparam logic [7:0] ANS_RESET = 8'h17;
   localparam logic [7:0] STEER_MASK = 8'h3B;
   localparam logic [7:0] STEER_RESET = 8'h00;
   localparam logic [5:0] PIN_MASK = 6'h3F;
   localparam logic [5:0] OE_MASK = 6'h37;

   // Steering bit positions
   localparam int STEER_NCO = 0;
   localparam int STEER_CLC = 1;
   localparam int STEER_GATE = 3;
   localparam int STEER_SS = 4;
   localparam int STEER_SDO = 5;

   // Pin positions
   localparam int PA2 = 2;
   localparam int PA3 = 3;
   localparam int PA4 = 4;
   localparam int PC1 = 1;
   localparam int PC2 = 2;
   localparam int PC3 = 3;
   localparam int PC5 = 5;

   typedef enum logic {BUS_SETUP, BUS_ACCESS} bus_state_t;

   // Two-way pin choice: a when sel is set, b otherwise
   function automatic logic pick(input logic sel, input logic a, input logic b);
      return sel ? a : b;
   endfunction

   // Place an 8-bit register in the low bits of a bus word
   function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
      return {24'h000000, v};
   endfunction
endpackage

/* common/route_if.sv */
// Signals passed between the port top and its drive and input routing cells
`timescale 1ns/10ps
interface route_if;
   logic [7:0] steer;
   logic [7:0] dir;
   logic [7:0] lat;
   logic [7:0] ans;
   logic [5:0] pa_in;
   logic [5:0] pc_in;
   logic sdo;
   logic sdo_en;
   logic clc;
   logic clc_en;
   logic nco;
   logic nco_en;
   logic [5:0] pa_val;
   logic [5:0] pa_en;
   logic [5:0] pc_val;
   logic [5:0] pc_own;
   logic [5:0] pin_read;
   logic ss;
   logic gate;

   modport drv (input steer, dir, lat, sdo, sdo_en, clc, clc_en, nco, nco_en,
      output pa_val, pa_en, pc_val, pc_own);
   modport rcv (input steer, ans, pa_in, pc_in, output pin_read, ss, gate);
   modport top (output steer, dir, lat, ans, pa_in, pc_in, sdo, sdo_en, clc, clc_en,
      nco, nco_en, input pa_val, pa_en, pc_val, pc_own, pin_read, ss, gate);
endinterface

/* logic/gpio_port.sv */
// Six-pin general purpose port with pin steering, reached over APB
//
// How it works
// [R1] Direction one: pin is input, driver off
// [R2] Direction zero: drive pin from latch
// [R3] Input-only pin undriven, direction reads one
// [R4] Pin value reads pins, writes latch
// [R5] Latch writes alike, reads latch
// [R6] Pin value write lands in latch
// [R7] Analog select disables digital input buffer
// [R8] Analog pins read zero digitally
// [R9] Analog select leaves output driving untouched
// [R10] Direction controls drivers on analog pins
// [R11] Analog select resets to analog mode
// [R12] Peripheral owns pin data, pin stays readable
// [R13] Six pins, each direction, latch, read
// [R14] Bit 5 moves serial out pin
// [R15] Bit 4 picks slave select source
// [R16] Bit 3 picks timer gate source
// [R17] Bit 1 moves logic cell output
// [R18] Bit 0 moves oscillator output
// [R19] Steering leaves direction alone, follows pin
// [R20] Unused steering bits read zero
// [R21] Highest priority enabled source wins pin
// [R22] Writes act next edge, steering resets zero
`timescale 1ns/10ps
module gpio_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [gpio_steer_pkg::ADDR_W-1:0] paddr,
   input wire logic [gpio_steer_pkg::DATA_W-1:0] pwdata,
   output logic [gpio_steer_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [gpio_steer_pkg::PORT_W-1:0] pa_pin_in,
   output logic [gpio_steer_pkg::PORT_W-1:0] pa_pin_out,
   output logic [gpio_steer_pkg::PORT_W-1:0] pa_pin_oe,
   input wire logic [gpio_steer_pkg::PORT_W-1:0] pc_pin_in,
   output logic [gpio_steer_pkg::PORT_W-1:0] pc_pin_out,
   output logic [gpio_steer_pkg::PORT_W-1:0] pc_pin_own,
   input wire logic serial_out_data,
   input wire logic serial_out_en,
   input wire logic logic_cell_output,
   input wire logic logic_cell_en,
   input wire logic osc_accum_output,
   input wire logic osc_accum_en,
   output logic slave_select_in,
   output logic timer_gate_input
);
   import gpio_steer_pkg::*;

   typedef struct packed {
      bus_state_t st;
      logic [7:0] dir;
      logic [7:0] lat;
      logic [7:0] ans;
      logic [7:0] steer;
      logic rdy;
      logic err;
      logic [DATA_W-1:0] rdata;
      logic [5:0] pa_out;
      logic [5:0] pa_oe;
      logic [5:0] pc_out;
      logic [5:0] pc_own;
      logic ss;
      logic gate;
   } state_t;

   localparam state_t STATE_RESET = '{
      st: BUS_SETUP,
      dir: DIR_RESET,
      lat: LAT_RESET,
      ans: ANS_RESET,
      steer: STEER_RESET,
      rdy: 1'b0,
      err: 1'b0,
      rdata: '0,
      pa_out: '0,
      pa_oe: '0,
      pc_out: '0,
      pc_own: '0,
      ss: 1'b0,
      gate: 1'b0
   };

   state_t cur;
   state_t next_cur;
   route_if rt();
   logic setup_phase;
   logic write_done;
   logic addr_known;

   // Register contents and pins fed to the routing cells
   assign rt.steer = cur.steer;
   assign rt.dir = cur.dir;
   assign rt.lat = cur.lat;
   assign rt.ans = cur.ans;
   assign rt.pa_in = pa_pin_in;
   assign rt.pc_in = pc_pin_in;
   assign rt.sdo = serial_out_data;
   assign rt.sdo_en = serial_out_en;
   assign rt.clc = logic_cell_output;
   assign rt.clc_en = logic_cell_en;
   assign rt.nco = osc_accum_output;
   assign rt.nco_en = osc_accum_en;

   pin_drive_mux u_drive (
      .rt(rt.drv)
   );

   pin_input_route u_input (
      .rt(rt.rcv)
   );

   // Bus phase decode
   assign setup_phase = psel && !penable && (cur.st == BUS_SETUP);
   assign write_done = psel && penable && cur.rdy && pwrite && (cur.st == BUS_ACCESS);
   assign addr_known = (paddr == OFS_DIR) || (paddr == OFS_PIN) || (paddr == OFS_LAT) ||
      (paddr == OFS_ANS) || (paddr == OFS_STEER);

   // Next state: bus answer, register writes, pin drive and input capture
   always_comb begin
      next_cur = cur;
      case (cur.st)
         BUS_SETUP: begin
            if (setup_phase) begin
               next_cur.st = BUS_ACCESS;
               next_cur.rdy = 1'b1;
               next_cur.err = !addr_known;
               next_cur.rdata = '0;
               if (!pwrite) begin
                  case (paddr)
                     OFS_DIR: next_cur.rdata = widen(cur.dir | DIR_FORCE); // [R3]
                     OFS_PIN: next_cur.rdata = widen({2'b00, rt.pin_read}); // [R4] [R13]
                     OFS_LAT: next_cur.rdata = widen(cur.lat); // [R5]
                     OFS_ANS: next_cur.rdata = widen(cur.ans);
                     OFS_STEER: next_cur.rdata = widen(cur.steer); // [R20]
                     default: next_cur.rdata = '0;
                  endcase
               end
            end
         end
         BUS_ACCESS: begin
            if (psel && penable) begin
               next_cur.st = BUS_SETUP;
               next_cur.rdy = 1'b0;
               next_cur.err = 1'b0;
               if (write_done) begin
                  case (paddr)
                     OFS_DIR: next_cur.dir = (pwdata[7:0] & DIR_MASK) | DIR_FORCE; // [R3] [R22]
                     OFS_PIN: next_cur.lat = pwdata[7:0] & LAT_MASK; // [R4] [R6] [R22]
                     OFS_LAT: next_cur.lat = pwdata[7:0] & LAT_MASK; // [R5] [R22]
                     OFS_ANS: next_cur.ans = pwdata[7:0] & ANS_MASK;
                     OFS_STEER: next_cur.steer = pwdata[7:0] & STEER_MASK; // [R20] [R22]
                     default: next_cur.dir = cur.dir;
                  endcase
               end
            end
         end
         default: begin
            next_cur.st = BUS_SETUP;
            next_cur.rdy = 1'b0;
         end
      endcase
      next_cur.pa_out = rt.pa_val; // [R2] [R12] [R21]
      next_cur.pa_oe = rt.pa_en; // [R1] [R3] [R10]
      next_cur.pc_out = rt.pc_val; // [R19]
      next_cur.pc_own = rt.pc_own; // [R19]
      next_cur.ss = rt.ss; // [R15]
      next_cur.gate = rt.gate; // [R16]
   end

   // State register; reset restores analog mode and clears steering
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= STATE_RESET; // [R11] [R22]
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from the state register
   assign prdata = cur.rdata;
   assign pready = cur.rdy;
   assign pslverr = cur.err;
   assign pa_pin_out = cur.pa_out;
   assign pa_pin_oe = cur.pa_oe;
   assign pc_pin_out = cur.pc_out;
   assign pc_pin_own = cur.pc_own;
   assign slave_select_in = cur.ss;
   assign timer_gate_input = cur.gate;

   // Checks on the behaviour seen at the ports
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_in_only_undriven: assert property (!pa_pin_oe[PA3]) // [R3]
      else $error("input-only pin driven");

   a_input_no_drive: assert property (##1 (pa_pin_oe & $past(cur.dir[5:0])) == 6'h00) // [R1]
      else $error("driver on for a pin set as input");

   a_output_drive: assert property ( // [R2]
      ##1 (pa_pin_oe == (~$past(cur.dir[5:0]) & OE_MASK)))
      else $error("driver off for a pin set as output");

   a_latch_on_pin: assert property ( // [R9]
      (!cur.dir[0] && cur.ans[0]) |=> (pa_pin_oe[0] && pa_pin_out[0] == $past(cur.lat[0])))
      else $error("analog pin not driving its latch");

   a_dir_reads_one: assert property (
      (setup_phase && !pwrite && paddr == OFS_DIR) |=> (pready && prdata[PA3])) // [R3]
      else $error("input-only direction bit read as zero");

   a_pin_write_lat: assert property ( // [R4]
      (write_done && paddr == OFS_PIN) |=> cur.lat == ($past(pwdata[7:0]) & LAT_MASK))
      else $error("pin value write missed the latch");

   a_lat_readback: assert property ( // [R5]
      (setup_phase && !pwrite && paddr == OFS_LAT) |=> prdata == widen($past(cur.lat)))
      else $error("latch read did not return latch");

   a_analog_zero: assert property ( // [R8]
      (setup_phase && !pwrite && paddr == OFS_PIN) |=>
      (prdata[5:0] & $past(cur.ans[5:0])) == 6'h00)
      else $error("analog pin read nonzero");

   a_reset_values: assert property ( // [R11]
      !$past(presetn) |-> (cur.ans == ANS_RESET && cur.steer == STEER_RESET))
      else $error("wrong reset value");

   a_steer_reserved: assert property ((cur.steer & ~STEER_MASK) == 8'h00) // [R20]
      else $error("unused steering bit set");

   a_ss_route: assert property ( // [R15]
      ##1 slave_select_in == ($past(cur.steer[STEER_SS]) ? $past(rt.pin_read[PA3]) :
      $past(pc_pin_in[PC3])))
      else $error("slave select taken from wrong pin");

   a_gate_route: assert property ( // [R16]
      (cur.steer[STEER_GATE] == 1'b0) |=> timer_gate_input == $past(rt.pin_read[PA4]))
      else $error("timer gate taken from wrong pin");

   a_sdo_default: assert property ( // [R14]
      (serial_out_en && !cur.steer[STEER_SDO]) |=>
      (pc_pin_own[PC2] && pc_pin_out[PC2] == $past(serial_out_data)))
      else $error("serial out not on its default pin");

   a_clc_alt: assert property ( // [R17]
      (logic_cell_en && cur.steer[STEER_CLC]) |=>
      (pc_pin_own[PC5] && pa_pin_out[PA2] == $past(cur.lat[PA2])))
      else $error("logic cell output not on its alternate pin");

   a_osc_priority: assert property ( // [R18] [R21]
      (osc_accum_en && cur.steer[STEER_NCO] && serial_out_en && cur.steer[STEER_SDO]) |=>
      pa_pin_out[PA4] == $past(osc_accum_output))
      else $error("oscillator lost priority on its pin");

   a_bus_answer: assert property (setup_phase |=> pready ##1 !pready) // [R22]
      else $error("bus answer not exactly one cycle");

   c_pin_write: cover property (write_done && paddr == OFS_PIN);
   c_pin_read: cover property (setup_phase && !pwrite && paddr == OFS_PIN);
   c_steer_alt: cover property (cur.steer[STEER_SDO] && serial_out_en);
   c_unmapped: cover property (pready && pslverr);
endmodule

/* logic/pin_drive_mux.sv */
// Output drive selection for the port and the steered peripheral outputs
`timescale 1ns/10ps
module pin_drive_mux (
   route_if.drv rt
);
   import gpio_steer_pkg::*;

   // Pin data: highest priority enabled peripheral first, latch last
   always_comb begin
      rt.pa_val = rt.lat[5:0];
      if (rt.clc_en && !rt.steer[STEER_CLC]) begin // [R17] [R12]
         rt.pa_val[PA2] = rt.clc;
      end
      if (rt.nco_en && rt.steer[STEER_NCO]) begin // [R18] [R21]
         rt.pa_val[PA4] = rt.nco;
      end else if (rt.sdo_en && rt.steer[STEER_SDO]) begin // [R14] [R21]
         rt.pa_val[PA4] = rt.sdo;
      end
   end

   // Drivers follow direction only, never analog select or steering
   assign rt.pa_en = ~rt.dir[5:0] & OE_MASK; // [R1] [R2] [R3] [R9] [R10] [R19]

   // Port C overrides land only on the selected pin
   always_comb begin
      rt.pc_val = '0;
      rt.pc_own = '0;
      rt.pc_val[PC1] = rt.nco;
      rt.pc_own[PC1] = rt.nco_en && !rt.steer[STEER_NCO]; // [R18] [R19]
      rt.pc_val[PC2] = rt.sdo;
      rt.pc_own[PC2] = rt.sdo_en && !rt.steer[STEER_SDO]; // [R14] [R19]
      rt.pc_val[PC5] = rt.clc;
      rt.pc_own[PC5] = rt.clc_en && rt.steer[STEER_CLC]; // [R17] [R19]
   end
endmodule

/* logic/pin_input_route.sv */
// Digital input buffers and steering of peripheral inputs
`timescale 1ns/10ps
module pin_input_route (
   route_if.rcv rt
);
   import gpio_steer_pkg::*;

   // Analog pins have their digital buffer off and read as zero
   assign rt.pin_read = rt.pa_in & ~rt.ans[5:0] & PIN_MASK; // [R7] [R8] [R12]

   // Peripheral inputs taken from the selected pin
   assign rt.ss = pick(rt.steer[STEER_SS], rt.pin_read[PA3], rt.pc_in[PC3]); // [R15]
   assign rt.gate = pick(rt.steer[STEER_GATE], rt.pin_read[PA3], rt.pin_read[PA4]); // [R16]
endmodule

/* tb/pin_world.sv */
// Model of the pins and outside world around the port
`timescale 1ns/10ps
module pin_world (
   input wire logic [5:0] pa_pin_out,
   input wire logic [5:0] pa_pin_oe,
   input wire logic [5:0] ext_pa,
   input wire logic [5:0] ext_pc,
   output logic [5:0] pa_pin_in,
   output logic [5:0] pc_pin_in
);
   // A driven pin shows the port's value, an undriven one the outside level
   assign pa_pin_in = (pa_pin_oe & pa_pin_out) | (~pa_pin_oe & ext_pa);
   assign pc_pin_in = ext_pc;
endmodule

/* tb/test_gpio_port_with_pin_steering.sv */
// Self-checking testbench for the port with pin steering
`timescale 1ns/10ps
module test_gpio_port_with_pin_steering;
   import gpio_steer_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, ss, gate;
   logic [5:0] pa_in, pa_out, pa_oe, pc_in, pc_out, pc_own;
   logic [5:0] ext_pa = 6'h00, ext_pc = 6'h00;
   logic sdo = 1'b0, sdo_en = 1'b0, clc = 1'b0, clc_en = 1'b0, osc = 1'b0, osc_en = 1'b0;
   int mismatches = 0, cmp_count = 0;

   gpio_port gpio_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pa_pin_in(pa_in), .pa_pin_out(pa_out), .pa_pin_oe(pa_oe),
      .pc_pin_in(pc_in), .pc_pin_out(pc_out), .pc_pin_own(pc_own), .serial_out_data(sdo),
      .serial_out_en(sdo_en), .logic_cell_output(clc), .logic_cell_en(clc_en),
      .osc_accum_output(osc), .osc_accum_en(osc_en), .slave_select_in(ss),
      .timer_gate_input(gate));
   pin_world pin_world_i (.pa_pin_out(pa_out), .pa_pin_oe(pa_oe), .ext_pa(ext_pa),
      .ext_pc(ext_pc), .pa_pin_in(pa_in), .pc_pin_in(pc_in));

   // 25 MHz clock
   initial begin
      forever #20 pclk = ~pclk;
   end

   task results;
      if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; starts just after a rising edge, waits for pready
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         results();
      end
      // Let one idle edge pass so the next call never reassigns psel in this step
      @(posedge pclk);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, a, {24'h0, d}, r, e);
   endtask

   task rd(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] r;
      logic e;
      xfer(1'b0, a, 32'h0, r, e);
      chk("read data", {24'h0, exp}, r);
      chk("read error", 32'h0, {31'h0, e});
   endtask

   task settle;
      repeat (2) @(posedge pclk);
   endtask

   task t_reset;
      rd(OFS_DIR, 8'h3F);
      rd(OFS_LAT, 8'h00);
      rd(OFS_ANS, 8'h17);
      rd(OFS_STEER, 8'h00);
      chk("oe after reset", 32'h0, {26'h0, pa_oe});
   endtask

   task t_drive;
      ext_pa <= 6'h2D;
      wr(OFS_ANS, 8'h00);
      wr(OFS_DIR, 8'h00);
      rd(OFS_DIR, 8'h08);
      wr(OFS_PIN, 8'h15);
      rd(OFS_LAT, 8'h15);
      settle();
      chk("oe all out", 32'h37, {26'h0, pa_oe});
      chk("out from latch", 32'h15, {26'h0, pa_out & 6'h37});
      wr(OFS_LAT, 8'h22);
      settle();
      chk("out after latch write", 32'h22, {26'h0, pa_out & 6'h37});
      rd(OFS_PIN, 8'h2A);
   endtask

   task t_analog;
      ext_pa <= 6'h3F;
      wr(OFS_DIR, 8'h3F);
      wr(OFS_ANS, 8'h17);
      rd(OFS_PIN, 8'h28);
      wr(OFS_ANS, 8'h00);
      rd(OFS_PIN, 8'h3F);
      wr(OFS_ANS, 8'h17);
      wr(OFS_DIR, 8'h00);
      wr(OFS_LAT, 8'h37);
      settle();
      chk("oe on analog", 32'h37, {26'h0, pa_oe});
      chk("out on analog", 32'h37, {26'h0, pa_out & 6'h37});
      rd(OFS_LAT, 8'h37);
      wr(OFS_ANS, 8'h00);
      wr(OFS_LAT, 8'h00);
   endtask

   task t_steer;
      logic [31:0] r;
      logic e;
      osc <= 1'b1; osc_en <= 1'b1; sdo <= 1'b1; sdo_en <= 1'b1; clc <= 1'b1; clc_en <= 1'b1;
      wr(OFS_STEER, 8'hFF);
      rd(OFS_STEER, 8'h3B);
      rd(OFS_DIR, 8'h08);
      wr(OFS_STEER, 8'h01);
      settle();
      chk("osc on pin4", 32'h1, {31'h0, pa_out[PA4]});
      chk("pc1 released", 32'h0, {31'h0, pc_own[PC1]});
      wr(OFS_STEER, 8'h00);
      settle();
      chk("osc on pc1", 32'h3, {30'h0, pc_own[PC1], pc_out[PC1]});
      chk("sdo on pc2", 32'h1, {31'h0, pc_own[PC2]});
      chk("clc on pin2", 32'h1, {31'h0, pa_out[PA2]});
      chk("pin4 from latch", 32'h0, {31'h0, pa_out[PA4]});
      wr(OFS_STEER, 8'h22);
      settle();
      chk("sdo on pin4", 32'h1, {31'h0, pa_out[PA4]});
      chk("clc on pc5", 32'h1, {31'h0, pc_own[PC5]});
      chk("pin2 from latch", 32'h0, {31'h0, pa_out[PA2]});
      sdo <= 1'b0;
      wr(OFS_STEER, 8'h21);
      settle();
      chk("osc beats sdo", 32'h1, {31'h0, pa_out[PA4]});
      wr(OFS_DIR, 8'h3F);
      ext_pa <= 6'h08; ext_pc <= 6'h00;
      wr(OFS_STEER, 8'h18);
      settle();
      chk("gate from pin3", 32'h1, {31'h0, gate});
      chk("ss from pin3", 32'h1, {31'h0, ss});
      wr(OFS_STEER, 8'h00);
      settle();
      chk("gate from pin4", 32'h0, {31'h0, gate});
      chk("ss from pc3", 32'h0, {31'h0, ss});
      rd(OFS_PIN, 8'h08);
      xfer(1'b0, 8'h14, 32'h0, r, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_drive();
      t_analog();
      t_steer();
      results();
   end
endmodule
